// File: dv/lane_tx_model.sv
// behavioural link transmitter: sync characters, lane alignment sequence, then counting data
`timescale 1ns/1ps
module lane_tx_model #(
	parameter int LANES = 8
)(
	// clock and link handshake
	input  wire logic           clk,
	input  wire logic           syncIn_n,
	input  wire logic           lmfcIn,
	// decoded words per lane, octet 0 in the low byte
	output logic [LANES*32-1:0] laneWords,
	output logic [LANES*4-1:0]  laneCtrl
);
	int step = -1;

	always @(posedge clk)
	begin
		if (!syncIn_n)
			step <= -1;
		else if (step >= 0 || lmfcIn)
			step <= step + 1;
	end

	function automatic logic [35:0] word_at(input int k);
		if (k < 0)
			return {4'hf, 32'hbcbc_bcbc};
		else if (k == 0)
			return {4'h7, 32'h001c_7cbc};
		return {4'h0, 8'(k + 3), 8'(k + 2), 8'(k + 1), 8'(k)};
	endfunction

	// odd lanes run one word late so the receiver has skew to remove
	always_comb
		for (int l = 0; l < LANES; l++)
			{laneCtrl[l*4+:4], laneWords[l*32+:32]} = word_at(step - l % 2);
endmodule

// File: dv/serial_rx_pll_cdr_link_sync_bench.sv
// self-checking bench: registers, pll status and events, cdr setup, link sync and deskew
`timescale 1ns/1ps
module serial_rx_pll_cdr_link_sync_bench;
	import link_rx_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         ce = 1'b1;
	logic [11:0]  regAddr = 12'h000;
	logic [7:0]   regWrData = 8'h00;
	logic         regWrStrobe = 1'b0;
	logic         regRdStrobe = 1'b0;
	logic         pllLockIn = 1'b0;
	logic         pllCalDoneIn = 1'b0;
	logic         pllCalHighIn = 1'b0;
	logic         pllCalLowIn = 1'b0;
	logic         lmfcEdge = 1'b0;
	logic         syncPrev = 1'b0;
	logic [255:0] serialLaneInput;
	logic [31:0]  serialLaneIsCtrl;
	logic [7:0]   regRdData, lanePowerOffMask, cdrLaneTrackEn, alignedValid;
	logic [1:0]   lanePllDividerCode, equalizerPowerSelect;
	logic         pllEnableOut, pllRecalOut, cdrHalfRateOn, cdrDoubleSamplingOn, cdrResetOut;
	logic         eqLowPowerOut, irqOut, link0SyncRequestOut_n, link1SyncRequestOut_n;
	logic [255:0] alignedOctets;
	logic [31:0]  alignedCtrl, frameStartMark;
	int           failures = 0;
	int           samples_checked = 0;
	int           cycles = 0;
	int           lastLmfc = 0;
	int           riseGap = 0;

	serial_rx_pll_cdr_link_sync u_serial_rx_pll_cdr_link_sync (
		.clk_sys, .rst, .ce, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
		.pllLockIn, .pllCalDoneIn, .pllCalHighIn, .pllCalLowIn, .pllEnableOut, .pllRecalOut,
		.lanePllDividerCode, .cdrHalfRateOn, .cdrDoubleSamplingOn, .cdrResetOut, .lanePowerOffMask,
		.cdrLaneTrackEn, .equalizerPowerSelect, .eqLowPowerOut, .irqOut, .lmfcEdge, .serialLaneInput,
		.serialLaneIsCtrl, .link0SyncRequestOut_n, .link1SyncRequestOut_n, .alignedOctets,
		.alignedCtrl, .frameStartMark, .alignedValid
	);
	lane_tx_model u_lane_tx_model (
		.clk(clk_sys), .syncIn_n(link0SyncRequestOut_n), .lmfcIn(lmfcEdge),
		.laneWords(serialLaneInput), .laneCtrl(serialLaneIsCtrl)
	);

	always #5 clk_sys = ~clk_sys;

	// multiframe pulse every eight cycles; sync rise distance from the last pulse is recorded
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		lmfcEdge <= (cycles[2:0] == 3'h7);
		syncPrev <= link0SyncRequestOut_n;
		if (lmfcEdge)
			lastLmfc <= cycles;
		if (link0SyncRequestOut_n && !syncPrev)
			riseGap <= cycles - lastLmfc;
		if (cycles == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
			failures++;
		end
	endtask

	// strobe is dropped one edge before the task returns so calls may follow directly
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge clk_sys);
		regWrStrobe <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [7:0] mask, input logic [7:0] exp, input string what);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge clk_sys);
		regRdStrobe <= 1'b0;
		@(posedge clk_sys);
		chk(what, exp, regRdData & mask);
	endtask

	task automatic t_regs();
		logic [7:0] tune [TUNE_COUNT] = '{8'h62, 8'hc9, 8'h0e, 8'h12, 8'h7b, 8'h00, 8'h89, 8'h24,
			8'h03, 8'h0d, 8'h02, 8'h8e, 8'h2a, 8'h78, 8'h06};
		chk("sync0 after reset", 0, link0SyncRequestOut_n);
		chk("sync1 after reset", 0, link1SyncRequestOut_n);
		rdchk(PLL_DIVIDER_OFF, 8'hff, 8'h00, "divider reset");
		ce <= 1'b0;
		wr(PLL_DIVIDER_OFF, 8'h03);
		ce <= 1'b1;
		rdchk(PLL_DIVIDER_OFF, 8'hff, 8'h00, "write while frozen");
		rdchk(POWER_DOWN_OFF, 8'hff, 8'h00, "power reset");
		wr(12'h2ff, 8'haa);
		rdchk(12'h2ff, 8'hff, 8'h00, "unmapped");
		wr(PLL_STATE_OFF, 8'hff);
		rdchk(PLL_STATE_OFF, 8'h39, 8'h00, "state read only");
		for (int i = 0; i < TUNE_COUNT; i++)
			wr(TUNE_OFFS[i], tune[i]);
		for (int i = 0; i < TUNE_COUNT; i++)
			rdchk(TUNE_OFFS[i], 8'hff, tune[i], "tuning");
		$display("test registers done");
	endtask

	task automatic t_pll();
		logic [1:0] codes [3] = '{DIV_CODE_BY1, DIV_CODE_BY2, DIV_CODE_BY4};
		for (int i = 0; i < 3; i++)
		begin
			wr(PLL_DIVIDER_OFF, {6'h00, codes[i]});
			@(posedge clk_sys);
			chk("divider code", codes[i], lanePllDividerCode);
			rdchk(PLL_STATE_OFF, 8'h40, {1'b0, codes[i] == DIV_CODE_BY2, 6'h00}, "pfd range");
		end
		wr(PLL_DIVIDER_OFF, {6'h00, DIV_CODE_BY2});
		wr(IRQ_EN_OFF, 8'h0c);
		wr(PLL_CTRL_OFF, 8'h01);
		@(posedge clk_sys);
		chk("pll enable", 1, pllEnableOut);
		pllLockIn <= 1'b1;
		pllCalDoneIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdchk(PLL_STATE_OFF, 8'h39, 8'h09, "lock and cal");
		rdchk(IRQ_STATUS_OFF, 8'h0c, 8'h04, "lock event");
		chk("irq on lock", 1, irqOut);
		wr(IRQ_STATUS_OFF, 8'h04);
		@(posedge clk_sys);
		chk("irq cleared", 0, irqOut);
		pllLockIn <= 1'b0;
		pllCalHighIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdchk(PLL_STATE_OFF, 8'h39, 8'h18, "band high");
		chk("irq on loss", 1, irqOut);
		wr(IRQ_EN_OFF, 8'h00);
		@(posedge clk_sys);
		chk("irq masked", 0, irqOut);
		wr(IRQ_STATUS_OFF, 8'h0c);
		pllCalHighIn <= 1'b0;
		pllCalLowIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdchk(PLL_STATE_OFF, 8'h39, 8'h28, "band low");
		wr(PLL_CTRL_OFF, 8'h01);
		@(posedge clk_sys);
		chk("recal low", 0, pllRecalOut);
		wr(PLL_CTRL_OFF, 8'h05);
		@(posedge clk_sys);
		chk("recal high", 1, pllRecalOut);
		$display("test pll done");
	endtask

	task automatic t_lanes();
		logic [7:0] modes [3] = '{8'h02, 8'h00, 8'h20};
		for (int i = 0; i < 3; i++)
		begin
			wr(CDR_SAMPLING_OFF, modes[i]);
			@(posedge clk_sys);
			chk("cdr mode", {modes[i][5], modes[i][1]}, {cdrHalfRateOn, cdrDoubleSamplingOn});
		end
		wr(EQUALIZER_OFF, 8'h40);
		@(posedge clk_sys);
		chk("eq low power", 3'b011, {equalizerPowerSelect, eqLowPowerOut});
		wr(EQUALIZER_OFF, 8'h00);
		@(posedge clk_sys);
		chk("eq normal", 3'b000, {equalizerPowerSelect, eqLowPowerOut});
		wr(POWER_DOWN_OFF, 8'hf0);
		wr(CDR_RESET_OFF, 8'h01);
		@(posedge clk_sys);
		chk("cdr in reset", 9'h100, {cdrResetOut, cdrLaneTrackEn});
		wr(CDR_RESET_OFF, 8'h00);
		@(posedge clk_sys);
		chk("lane tracking", 17'h0_f00f, {cdrResetOut, lanePowerOffMask, cdrLaneTrackEn});
		$display("test lanes done");
	endtask

	task automatic t_link();
		wr(LINK_CFG_OFF, 8'h13);
		wr(CDR_RESET_OFF, 8'h01);
		@(posedge clk_sys);
		chk("sync requested", 0, link0SyncRequestOut_n);
		wr(CDR_RESET_OFF, 8'h00);
		for (int i = 0; i < 200 && link0SyncRequestOut_n !== 1'b1; i++)
			@(posedge clk_sys);
		@(posedge clk_sys);
		chk("sync release gap", 1, riseGap inside {1, 2});
		chk("link1 request", 0, link1SyncRequestOut_n);
		for (int i = 0; i < 200 && alignedValid[0] !== 1'b1; i++)
			@(posedge clk_sys);
		chk("valid lanes", 8'h0f, alignedValid);
		chk("align words", {4{32'h001c_7cbc}}, alignedOctets[127:0]);
		chk("align ctrl", 16'h7777, alignedCtrl[15:0]);
		chk("frame marks", 16'h5555, frameStartMark[15:0]);
		@(posedge clk_sys);
		chk("first data", {4{32'h0403_0201}}, alignedOctets[127:0]);
		$display("test link done");
	endtask

	// one config register serves both links, so their parameters cannot differ
	task automatic t_dual();
		wr(LINK_CFG_OFF, 8'h09);
		wr(CDR_RESET_OFF, 8'h01);
		wr(CDR_RESET_OFF, 8'h00);
		for (int i = 0; i < 200 && link1SyncRequestOut_n !== 1'b1; i++)
			@(posedge clk_sys);
		chk("both syncs", 2'b11, {link0SyncRequestOut_n, link1SyncRequestOut_n});
		for (int i = 0; i < 200 && alignedValid[2] !== 1'b1; i++)
			@(posedge clk_sys);
		chk("dual valid", 8'h0f, alignedValid);
		chk("dual marks", 16'hffff, frameStartMark[15:0]);
		chk("dual align", {4{32'h001c_7cbc}}, alignedOctets[127:0]);
		$display("test dual link done");
	endtask

	task automatic t_reset();
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk("syncs after reset", 2'b00, {link0SyncRequestOut_n, link1SyncRequestOut_n});
		rdchk(LINK_CFG_OFF, 8'hff, LINK_CFG_RESET, "link config reset");
		$display("test reset done");
	endtask

	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_pll();
		t_lanes();
		t_link();
		t_dual();
		t_reset();
		give_verdict();
	end
endmodule

// File: verilog/link_rx_pkg.sv
// shared constants and types for the lane receive front end
package link_rx_pkg;
	localparam int          ADDR_W            = 12;
	localparam int          DATA_W            = 8;
	localparam int          OCTETS_PER_CLK    = 4;
	localparam int          OCTET_CODE_BITS   = 10;
	localparam int          LANE_TO_REF_RATIO = 40;
	localparam int          CLK_SYS_MHZ       = 100;
	localparam int          PFD_MIN_MHZ       = 35;
	localparam int          PFD_MAX_MHZ       = 80;
	localparam int          K_RUN_NEEDED      = 4;
	localparam int          TUNE_COUNT        = 15;

	localparam logic [11:0] IRQ_EN_OFF        = 12'h01f;
	localparam logic [11:0] IRQ_STATUS_OFF    = 12'h023;
	localparam logic [11:0] POWER_DOWN_OFF    = 12'h201;
	localparam logic [11:0] CDR_RESET_OFF     = 12'h206;
	localparam logic [11:0] CDR_SAMPLING_OFF  = 12'h230;
	localparam logic [11:0] EQUALIZER_OFF     = 12'h268;
	localparam logic [11:0] PLL_CTRL_OFF      = 12'h280;
	localparam logic [11:0] PLL_STATE_OFF     = 12'h281;
	localparam logic [11:0] PLL_DIVIDER_OFF   = 12'h289;
	localparam logic [11:0] LINK_CFG_OFF      = 12'h2f0;
	localparam logic [11:0] TUNE_OFFS [TUNE_COUNT] = '{12'h284, 12'h285, 12'h286, 12'h287, 12'h28a,
		12'h28b, 12'h290, 12'h294, 12'h296, 12'h297, 12'h299, 12'h29a, 12'h29c, 12'h29f, 12'h2a0};

	localparam logic [7:0]  REG_RESET         = 8'h00;
	localparam logic [7:0]  LINK_CFG_RESET    = 8'h00;

	localparam int          PLL_EN_BIT        = 0;
	localparam int          PLL_RECAL_BIT     = 2;
	localparam int          LOCK_BIT          = 0;
	localparam int          CAL_OK_BIT        = 3;
	localparam int          CAL_HIGH_BIT      = 4;
	localparam int          CAL_LOW_BIT       = 5;
	localparam int          PFD_OK_BIT        = 6;
	localparam int          IRQ_LOCK_BIT      = 2;
	localparam int          IRQ_LOST_BIT      = 3;
	localparam int          HALF_RATE_BIT     = 5;
	localparam int          DOUBLE_SAMP_BIT   = 1;
	localparam int          CDR_RST_BIT       = 0;
	localparam int          EQ_SEL_LSB        = 6;
	localparam int          LANES_M1_LSB      = 0;
	localparam int          DUAL_LINK_BIT     = 3;
	localparam int          FRAME_CODE_LSB    = 4;

	localparam logic [1:0]  EQ_LOW_POWER      = 2'h1;
	localparam logic [1:0]  EQ_NORMAL         = 2'h0;
	localparam logic [1:0]  DIV_CODE_BY1      = 2'h2;
	localparam logic [1:0]  DIV_CODE_BY2      = 2'h1;
	localparam logic [1:0]  DIV_CODE_BY4      = 2'h0;
	localparam logic [1:0]  FRAME_CODE_F1     = 2'h0;
	localparam logic [1:0]  FRAME_CODE_F2     = 2'h1;

	localparam logic [7:0]  K_SYNC            = 8'hbc;
	localparam logic [7:0]  K_ALIGN           = 8'h7c;
	localparam logic [7:0]  K_LANE_START      = 8'h1c;

	typedef enum {LINK_SYNC_REQ, LINK_WAIT_LMFC, LINK_WAIT_ILAS, LINK_RUN} link_state_e;
endpackage

// File: verilog/serial_rx_pll_cdr_link_sync.sv
// lane receive front end: pll control, cdr setup, link sync and lane deskew
//
// Function
// - octet rate is lane rate over ten
// - four octets handled per processing clock
// - frame marks follow octets per frame
// - reference divided into 35 to 80 MHz
// - status shows lock and calibration done
// - band-limit flags; software recalibrates by toggling
// - lock and lock-lost raise maskable interrupts
// - each lane tracks its phase independently
// - equalizer select: 01 low power, 00 normal
// - lanes allocated sequentially from zero
// - each link drives own sync output low
// - four /K/ then release at lmfc edge
// - align lanes on /A/ to /R/ transition
// - elastic buffers release all lanes of a link together
// - control characters mark frames and alignment
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module serial_rx_pll_cdr_link_sync
	import link_rx_pkg::*;
#(
	parameter int NUM_LANES = 8,
	parameter int BUF_DEPTH = 4
)(
	// clock, reset, enable
	input  wire logic                            clk_sys,
	input  wire logic                            rst,
	input  wire logic                            ce,
	// register port
	input  wire logic [link_rx_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [link_rx_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                            regWrStrobe,
	input  wire logic                            regRdStrobe,
	output logic      [link_rx_pkg::DATA_W-1:0]  regRdData,
	// analog pll status pins
	input  wire logic                            pllLockIn,
	input  wire logic                            pllCalDoneIn,
	input  wire logic                            pllCalHighIn,
	input  wire logic                            pllCalLowIn,
	// pll and cdr controls
	output logic                                 pllEnableOut,
	output logic                                 pllRecalOut,
	output logic      [1:0]                      lanePllDividerCode,
	output logic                                 cdrHalfRateOn,
	output logic                                 cdrDoubleSamplingOn,
	output logic                                 cdrResetOut,
	output logic      [NUM_LANES-1:0]            lanePowerOffMask,
	output logic      [NUM_LANES-1:0]            cdrLaneTrackEn,
	output logic      [1:0]                      equalizerPowerSelect,
	output logic                                 eqLowPowerOut,
	output logic                                 irqOut,
	// decoded lane words from the deserializer, octet 0 in the low byte
	input  wire logic                            lmfcEdge,
	input  wire logic [NUM_LANES*32-1:0]         serialLaneInput,
	input  wire logic [NUM_LANES*4-1:0]          serialLaneIsCtrl,
	// link sync, low requests synchronisation
	output logic                                 link0SyncRequestOut_n,
	output logic                                 link1SyncRequestOut_n,
	// aligned lane data
	output logic      [NUM_LANES*32-1:0]         alignedOctets,
	output logic      [NUM_LANES*4-1:0]          alignedCtrl,
	output logic      [NUM_LANES*4-1:0]          frameStartMark,
	output logic      [NUM_LANES-1:0]            alignedValid
);
	import link_rx_pkg::*;

	localparam int PTR_W = $clog2(BUF_DEPTH);
	localparam int LANE_RATE_MHZ = CLK_SYS_MHZ * OCTETS_PER_CLK * OCTET_CODE_BITS;
	localparam int REF_MHZ = LANE_RATE_MHZ / LANE_TO_REF_RATIO;

	if (NUM_LANES < 2 || NUM_LANES > 8 || BUF_DEPTH < 2 || (1 << PTR_W) != BUF_DEPTH)
	begin : g_param_check
		$error("unsupported lane count or buffer depth");
	end

	// registers
	logic [7:0]       irqEnable_r, irqStatus_r, cdrResetCtrl_r, cdrSampling_r, equalizer_r;
	logic [7:0]       pllCtrl_r, pllDivider_r, linkCfg_r;
	logic [7:0]       powerDown_r;
	logic [7:0]       tune_r [TUNE_COUNT];
	logic [3:0]       lockMeta_r, lockSync_r;
	logic             lockPrev_r;
	logic             pfdOk;
	logic [7:0]       pllState;
	logic [7:0]       rdData_nxt;
	logic [3:0]       lanesM1;
	logic             dualLink;
	link_state_e      linkState_r [2];
	logic [1:0]       linkSyncOut_r;
	logic [NUM_LANES-1:0] member [2];
	logic [NUM_LANES-1:0] laneRSeen, laneKReady;
	logic [PTR_W-1:0] wrPtr_r;
	logic [3:0]       frameMask;

	wire regWrite = ce && regWrStrobe;
	wire regRead  = ce && regRdStrobe;

	assign lanesM1  = {1'b0, linkCfg_r[LANES_M1_LSB +: 3]};
	assign dualLink = linkCfg_r[DUAL_LINK_BIT];

	// pfd input in range for the selected divide ratio
	always_comb
	begin
		case (pllDivider_r[1:0])
			DIV_CODE_BY1: pfdOk = (REF_MHZ >= PFD_MIN_MHZ) && (REF_MHZ <= PFD_MAX_MHZ);
			DIV_CODE_BY2: pfdOk = (REF_MHZ / 2 >= PFD_MIN_MHZ) && (REF_MHZ / 2 <= PFD_MAX_MHZ);
			DIV_CODE_BY4: pfdOk = (REF_MHZ / 4 >= PFD_MIN_MHZ) && (REF_MHZ / 4 <= PFD_MAX_MHZ);
			default:      pfdOk = 1'b0;
		endcase
	end

	// analog status pins: bit0 lock, 1 cal done, 2 band high, 3 band low
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			lockMeta_r <= 4'h0;
			lockSync_r <= 4'h0;
		end
		else if (ce)
		begin
			lockMeta_r <= {pllCalLowIn, pllCalHighIn, pllCalDoneIn, pllLockIn};
			lockSync_r <= lockMeta_r;
		end
	end

	always_comb
	begin
		pllState = 8'h00;
		pllState[LOCK_BIT]     = lockSync_r[0];
		pllState[CAL_OK_BIT]   = lockSync_r[1];
		pllState[CAL_HIGH_BIT] = lockSync_r[2];
		pllState[CAL_LOW_BIT]  = lockSync_r[3];
		pllState[PFD_OK_BIT]   = pfdOk;
	end

	// plain control registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			irqEnable_r    <= REG_RESET;
			powerDown_r    <= REG_RESET;
			cdrResetCtrl_r <= REG_RESET;
			cdrSampling_r  <= REG_RESET;
			equalizer_r    <= REG_RESET;
			pllCtrl_r      <= REG_RESET;
			pllDivider_r   <= REG_RESET;
			linkCfg_r      <= LINK_CFG_RESET;
			for (int i = 0; i < TUNE_COUNT; i++)
				tune_r[i] <= REG_RESET;
		end
		else if (regWrite)
		begin
			case (regAddr)
				IRQ_EN_OFF:       irqEnable_r    <= regWrData;
				POWER_DOWN_OFF:   powerDown_r    <= regWrData;
				CDR_RESET_OFF:    cdrResetCtrl_r <= regWrData;
				CDR_SAMPLING_OFF: cdrSampling_r  <= regWrData;
				EQUALIZER_OFF:    equalizer_r    <= regWrData;
				PLL_CTRL_OFF:     pllCtrl_r      <= regWrData;
				PLL_DIVIDER_OFF:  pllDivider_r   <= regWrData;
				LINK_CFG_OFF:     linkCfg_r      <= regWrData;
				default:
				begin
					for (int i = 0; i < TUNE_COUNT; i++)
						if (regAddr == TUNE_OFFS[i])
							tune_r[i] <= regWrData;
				end
			endcase
		end
	end

	// lock and lock-lost events; a new event beats a same-cycle clear
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			irqStatus_r <= REG_RESET;
			lockPrev_r  <= 1'b0;
			irqOut      <= 1'b0;
		end
		else if (ce)
		begin
			lockPrev_r <= lockSync_r[0];
			for (int b = 0; b < 8; b++)
			begin
				if (b == IRQ_LOCK_BIT && lockSync_r[0] && !lockPrev_r)
					irqStatus_r[b] <= 1'b1;
				else if (b == IRQ_LOST_BIT && !lockSync_r[0] && lockPrev_r)
					irqStatus_r[b] <= 1'b1;
				else if (regWrite && regAddr == IRQ_STATUS_OFF && regWrData[b])
					irqStatus_r[b] <= 1'b0;
			end
			irqOut <= |(irqStatus_r & irqEnable_r & 8'h0c);
		end
	end

	// read data stands only in the cycle after the strobe
	always_comb
	begin
		rdData_nxt = 8'h00;
		case (regAddr)
			IRQ_EN_OFF:       rdData_nxt = irqEnable_r;
			IRQ_STATUS_OFF:   rdData_nxt = irqStatus_r;
			POWER_DOWN_OFF:   rdData_nxt = powerDown_r;
			CDR_RESET_OFF:    rdData_nxt = cdrResetCtrl_r;
			CDR_SAMPLING_OFF: rdData_nxt = cdrSampling_r;
			EQUALIZER_OFF:    rdData_nxt = equalizer_r;
			PLL_CTRL_OFF:     rdData_nxt = pllCtrl_r;
			PLL_STATE_OFF:    rdData_nxt = pllState;
			PLL_DIVIDER_OFF:  rdData_nxt = pllDivider_r;
			LINK_CFG_OFF:     rdData_nxt = linkCfg_r;
			default:
			begin
				for (int i = 0; i < TUNE_COUNT; i++)
					if (regAddr == TUNE_OFFS[i])
						rdData_nxt = tune_r[i];
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			regRdData <= 8'h00;
		else if (ce)
			regRdData <= regRead ? rdData_nxt : 8'h00;
	end

	// analog-facing controls
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pllEnableOut         <= 1'b0;
			pllRecalOut          <= 1'b0;
			lanePllDividerCode   <= 2'h0;
			cdrHalfRateOn        <= 1'b0;
			cdrDoubleSamplingOn  <= 1'b0;
			cdrResetOut          <= 1'b0;
			lanePowerOffMask     <= '0;
			cdrLaneTrackEn       <= '0;
			equalizerPowerSelect <= EQ_NORMAL;
			eqLowPowerOut        <= 1'b0;
		end
		else if (ce)
		begin
			pllEnableOut         <= pllCtrl_r[PLL_EN_BIT];
			pllRecalOut          <= pllCtrl_r[PLL_RECAL_BIT];
			lanePllDividerCode   <= pllDivider_r[1:0];
			cdrHalfRateOn        <= cdrSampling_r[HALF_RATE_BIT];
			cdrDoubleSamplingOn  <= cdrSampling_r[DOUBLE_SAMP_BIT];
			cdrResetOut          <= cdrResetCtrl_r[CDR_RST_BIT];
			lanePowerOffMask     <= powerDown_r[NUM_LANES-1:0];
			// one enable per lane, so each cdr follows its own lane's phase
			cdrLaneTrackEn       <= ~powerDown_r[NUM_LANES-1:0] & {NUM_LANES{~cdrResetCtrl_r[CDR_RST_BIT]}};
			equalizerPowerSelect <= equalizer_r[EQ_SEL_LSB +: 2];
			eqLowPowerOut        <= (equalizer_r[EQ_SEL_LSB +: 2] == EQ_LOW_POWER);
		end
	end

	// frame starts within a word: F of 1, 2 or 4 gives 4/F frames per clock
	always_comb
	begin
		case (linkCfg_r[FRAME_CODE_LSB +: 2])
			FRAME_CODE_F1: frameMask = 4'hf;
			FRAME_CODE_F2: frameMask = 4'h5;
			default:       frameMask = 4'h1;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			wrPtr_r <= '0;
		else if (ce)
			wrPtr_r <= wrPtr_r + 1'b1;
	end

	// link membership: link 0 takes lanes from zero, link 1 the next group
	genvar gl, gk;
	generate
		for (gl = 0; gl < NUM_LANES; gl++)
		begin : g_member
			assign member[0][gl] = !powerDown_r[gl] && (gl <= lanesM1);
			assign member[1][gl] = !powerDown_r[gl] && dualLink && (gl > lanesM1) && (gl <= 2 * lanesM1 + 1);
		end

		for (gk = 0; gk < 2; gk++)
		begin : g_link
			wire allK = ((laneKReady & member[gk]) == member[gk]) && (member[gk] != '0);
			wire allR = ((laneRSeen & member[gk]) == member[gk]) && (member[gk] != '0);
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
				begin
					linkState_r[gk]   <= LINK_SYNC_REQ;
					linkSyncOut_r[gk] <= 1'b0;
				end
				else if (ce)
				begin
					// cdr reset or an idle link forces a fresh request
					if (cdrResetCtrl_r[CDR_RST_BIT] || member[gk] == '0)
					begin
						linkState_r[gk]   <= LINK_SYNC_REQ;
						linkSyncOut_r[gk] <= 1'b0;
					end
					else
					begin
						case (linkState_r[gk])
							LINK_SYNC_REQ:
								if (allK)
									linkState_r[gk] <= LINK_WAIT_LMFC;
							LINK_WAIT_LMFC:
								if (lmfcEdge)
								begin
									linkState_r[gk]   <= LINK_WAIT_ILAS;
									linkSyncOut_r[gk] <= 1'b1;
								end
							LINK_WAIT_ILAS:
								if (allR)
									linkState_r[gk] <= LINK_RUN;
							LINK_RUN:
								linkState_r[gk] <= LINK_RUN;
							default:
								linkState_r[gk] <= LINK_SYNC_REQ;
						endcase
					end
				end
			end
		end

		for (gl = 0; gl < NUM_LANES; gl++)
		begin : g_lane
			logic [35:0]      mem_r [BUF_DEPTH];
			logic [2:0]       kRun_r;
			logic             lastA_r, rSeen_r, released_r;
			logic [PTR_W-1:0] startPtr_r, rdPtr_r;
			logic [2:0]       kRun_nxt;
			logic             rHit, prevA;
			wire  [31:0]      octs = serialLaneInput[gl*32 +: 32];
			wire  [3:0]       isK  = serialLaneIsCtrl[gl*4 +: 4];
			wire              lk   = member[1][gl];
			wire              armed = (linkState_r[lk] == LINK_WAIT_ILAS);
			wire              running = (linkState_r[lk] == LINK_RUN);

			// consecutive /K/ count and /A/ followed by /R/ across octets
			always_comb
			begin
				kRun_nxt = kRun_r;
				rHit = 1'b0;
				prevA = lastA_r;
				for (int i = 0; i < OCTETS_PER_CLK; i++)
				begin
					if (isK[i] && octs[i*8 +: 8] == K_SYNC)
						kRun_nxt = (kRun_nxt >= 3'(K_RUN_NEEDED)) ? kRun_nxt : kRun_nxt + 1'b1;
					else
						kRun_nxt = 3'h0;
					// /A/ in the previous octet, or the last octet of the previous word
					if (isK[i] && octs[i*8 +: 8] == K_LANE_START && prevA)
						rHit = 1'b1;
					prevA = isK[i] && octs[i*8 +: 8] == K_ALIGN;
				end
			end
			assign laneKReady[gl] = (kRun_r >= 3'(K_RUN_NEEDED));
			assign laneRSeen[gl]  = rSeen_r;

			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
				begin
					kRun_r     <= 3'h0;
					lastA_r    <= 1'b0;
					rSeen_r    <= 1'b0;
					startPtr_r <= '0;
				end
				else if (ce)
				begin
					kRun_r  <= kRun_nxt;
					lastA_r <= isK[3] && octs[31:24] == K_ALIGN;
					if (!armed && !running)
						rSeen_r <= 1'b0;
					else if (armed && rHit && !rSeen_r)
					begin
						rSeen_r    <= 1'b1;
						startPtr_r <= wrPtr_r;
					end
				end
			end

			// elastic buffer: early lanes wait here until the latest lane's /R/
			always_ff @(posedge clk_sys)
			begin
				if (ce)
					mem_r[wrPtr_r] <= {isK, octs};
			end

			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
				begin
					released_r <= 1'b0;
					rdPtr_r    <= '0;
					alignedOctets[gl*32 +: 32] <= 32'h0000_0000;
					alignedCtrl[gl*4 +: 4]     <= 4'h0;
					frameStartMark[gl*4 +: 4]  <= 4'h0;
					alignedValid[gl]           <= 1'b0;
				end
				else if (ce)
				begin
					released_r <= running && member[lk][gl];
					// all lanes of the link start reading on the same cycle
					rdPtr_r <= (running && !released_r) ? startPtr_r + 1'b1 : rdPtr_r + 1'b1;
					alignedValid[gl] <= running && member[lk][gl];
					alignedOctets[gl*32 +: 32] <= mem_r[(running && !released_r) ? startPtr_r : rdPtr_r][31:0];
					alignedCtrl[gl*4 +: 4]     <= mem_r[(running && !released_r) ? startPtr_r : rdPtr_r][35:32];
					frameStartMark[gl*4 +: 4]  <= (running && member[lk][gl]) ? frameMask : 4'h0;
				end
			end
		end
	endgenerate

	assign link0SyncRequestOut_n = linkSyncOut_r[0];
	assign link1SyncRequestOut_n = linkSyncOut_r[1];

	property p_syncRiseOnLmfc;
		@(posedge clk_sys) disable iff (rst)
		$rose(linkSyncOut_r[0]) |-> $past(lmfcEdge) && $past(ce);
	endproperty
	a_syncRiseOnLmfc: assert property (p_syncRiseOnLmfc) else $error("sync released off lmfc edge");

	property p_cdrResetRequests;
		@(posedge clk_sys) disable iff (rst)
		ce && cdrResetCtrl_r[CDR_RST_BIT] |=> !linkSyncOut_r[0] && !linkSyncOut_r[1];
	endproperty
	a_cdrResetRequests: assert property (p_cdrResetRequests) else $error("sync not requested");

	property p_lockEvent;
		@(posedge clk_sys) disable iff (rst)
		ce && lockSync_r[0] && !lockPrev_r |=> irqStatus_r[IRQ_LOCK_BIT];
	endproperty
	a_lockEvent: assert property (p_lockEvent) else $error("lock event lost");

	property p_irqGate;
		@(posedge clk_sys) disable iff (rst)
		ce && !(irqEnable_r[IRQ_LOCK_BIT] || irqEnable_r[IRQ_LOST_BIT]) |=> !irqOut;
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("masked interrupt reached output");

	property p_lockRead;
		@(posedge clk_sys) disable iff (rst)
		regRead && regAddr == PLL_STATE_OFF |=> regRdData[LOCK_BIT] == $past(lockSync_r[0]);
	endproperty
	a_lockRead: assert property (p_lockRead) else $error("lock bit misread");

	property p_bandRead;
		@(posedge clk_sys) disable iff (rst)
		regRead && regAddr == PLL_STATE_OFF && lockSync_r[2] |=> regRdData[CAL_HIGH_BIT];
	endproperty
	a_bandRead: assert property (p_bandRead) else $error("band flag missing");

	property p_eqLowPower;
		@(posedge clk_sys) disable iff (rst)
		regWrite && regAddr == EQUALIZER_OFF && regWrData[7:6] == EQ_LOW_POWER ##1 ce |=> eqLowPowerOut;
	endproperty
	a_eqLowPower: assert property (p_eqLowPower) else $error("low power eq not selected");

	property p_lanesTogether;
		@(posedge clk_sys) disable iff (rst)
		ce && !cdrResetCtrl_r[CDR_RST_BIT] && linkState_r[0] == LINK_RUN |=>
			(alignedValid & member[0]) == member[0] || !$stable(member[0]);
	endproperty
	a_lanesTogether: assert property (p_lanesTogether) else $error("link lanes not released together");
endmodule
